/* File: design/ocss_map.vh */
`ifndef OCSS_MAP_VH
`define OCSS_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OCSS_OFS_LOW_SEL 8'ha8
`define OCSS_OFS_SEL45 8'ha9
`define OCSS_OFS_SEL67 8'haa
`define OCSS_OFS_RSVD 8'hab
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCSS_BIT_SYNC_A 4
`define OCSS_BIT_SYNC_B 5
`define OCSS_LO_FIELD 0
`define OCSS_HI_FIELD 4
`define OCSS_MASK_LOW 8'h3f
`define OCSS_MASK_SEL 8'h77
// ----------------------------------------
// Reset values
// ----------------------------------------
`define OCSS_RST_LOW_SEL 8'h0a
`define OCSS_RST_SEL45 8'h20
`define OCSS_RST_SEL67 8'h50
`define OCSS_RST_OUT_LOOP_B 8'h0a
`define OCSS_RST_OUT_UPPER 12'ha10
// ----------------------------------------
// Source codes
// ----------------------------------------
`define OCSS_SRC_LOOP_A 3'h0
`define OCSS_SRC_LOOP_B 3'h1
`define OCSS_SRC_OUT2 3'h2
`define OCSS_SRC_OUT3 3'h3
`define OCSS_SRC_REF_A 3'h4
`define OCSS_SRC_REF_B 3'h5
`define OCSS_SRC_RSVD 3'h6
`define OCSS_SRC_XTAL 3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define OCSS_SWITCH_GAP 2'h2
`endif

/* File: design/ocss_source_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "ocss_map.vh"
module ocss_source_ctrl (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Fine phase request from phase block
  input wire [3:0] fine_phase_out2,
  input wire [3:0] fine_phase_out3,
  // Source routing: loop_b select bit per low output, 3-bit source code per upper output
  output reg [7:0] out_loop_b_sel,
  output reg [11:0] out_upper_code,
  output reg [7:0] out_switching,
  // Divider control
  output reg [7:0] divider_hold,
  output reg [7:0] coarse_clear,
  output reg [3:0] fine_applied_out2,
  output reg [3:0] fine_applied_out3
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] low_sel_reg;
  reg [7:0] sel45_reg;
  reg [7:0] sel67_reg;
  reg [1:0] sync_prev_reg;
  reg [7:0] frozen_reg;
  reg [1:0] gap_reg [0:7];
  reg [7:0] pend_reg;
  integer i;
  integer k;

  // ----------------------------------------
  // Loop membership
  // ----------------------------------------
  // Loop driving an output: 0 loop_a, 1 loop_b, 2 neither
  function [1:0] src_loop;
    input [3:0] idx;
    input [7:0] low;
    input [11:0] up;
    reg [2:0] code;
    reg [1:0] res;
    begin
      res = 2'h2;
      code = 3'h0;
      if (idx < 4'h4) begin
        res = {1'b0, low[idx[1:0]]};
      end else begin
        code = up[(idx[1:0])*3 +: 3];
        case (code)
          `OCSS_SRC_LOOP_A: res = 2'h0;
          `OCSS_SRC_LOOP_B: res = 2'h1;
          `OCSS_SRC_OUT2: res = {1'b0, low[2]};
          `OCSS_SRC_OUT3: res = {1'b0, low[3]};
          // References, crystal and reserved 110 belong to no loop
          default: res = 2'h2;
        endcase
      end
      src_loop = res;
    end
  endfunction

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  wire sync_a = low_sel_reg[`OCSS_BIT_SYNC_A];
  wire sync_b = low_sel_reg[`OCSS_BIT_SYNC_B];
  // No rate check on direct references; software keeps them slow
  wire [11:0] up_codes = {sel67_reg[6:4], sel67_reg[2:0], sel45_reg[6:4], sel45_reg[2:0]};
  wire rise_a = sync_a & ~sync_prev_reg[0];
  wire rise_b = sync_b & ~sync_prev_reg[1];
  wire fall_a = sync_prev_reg[0] & ~sync_a;
  wire fall_b = sync_prev_reg[1] & ~sync_b;

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_sel_reg <= `OCSS_RST_LOW_SEL;
      sel45_reg <= `OCSS_RST_SEL45;
      sel67_reg <= `OCSS_RST_SEL67;
      reg_rdata <= 8'h00;
    end else begin
      // Reserved bits are stored as zero whatever is written
      if (reg_wr) begin
        case (reg_addr)
          `OCSS_OFS_LOW_SEL: low_sel_reg <= reg_wdata & `OCSS_MASK_LOW;
          `OCSS_OFS_SEL45: sel45_reg <= reg_wdata & `OCSS_MASK_SEL;
          `OCSS_OFS_SEL67: sel67_reg <= reg_wdata & `OCSS_MASK_SEL;
          default: ;
        endcase
      end
      // Read data stands until the next read
      if (reg_rd) begin
        case (reg_addr)
          `OCSS_OFS_LOW_SEL: reg_rdata <= low_sel_reg;
          `OCSS_OFS_SEL45: reg_rdata <= sel45_reg;
          `OCSS_OFS_SEL67: reg_rdata <= sel67_reg;
          // Unmapped and reserved offsets read as zero
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Divider hold and release
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_prev_reg <= 2'h0;
      frozen_reg <= 8'h00;
      divider_hold <= 8'h00;
      coarse_clear <= 8'h00;
      fine_applied_out2 <= 4'h0;
      fine_applied_out3 <= 4'h0;
    end else begin
      sync_prev_reg <= {sync_b, sync_a};
      coarse_clear <= 8'h00;

      // Outputs on no loop (references, crystal) are never held
      for (i = 0; i < 8; i = i + 1) begin
        // Membership is fixed at the rising edge so a later reselect
        // cannot leave one divider released early
        if (rise_a &&
            src_loop(i[3:0], low_sel_reg, up_codes) == 2'h0) begin
          frozen_reg[i] <= 1'b0;
          divider_hold[i] <= 1'b1;
        end else if (rise_b &&
                     src_loop(i[3:0], low_sel_reg, up_codes) == 2'h1) begin
          frozen_reg[i] <= 1'b1;
          divider_hold[i] <= 1'b1;
        end else if (divider_hold[i] &&
                     ((fall_a && !frozen_reg[i]) || (fall_b && frozen_reg[i]))) begin
          divider_hold[i] <= 1'b0;
          coarse_clear[i] <= 1'b1;
        end
      end
      // Fine value only moves on release; coarse is cleared then,
      // so software sets fine before coarse
      if ((fall_a && low_sel_reg[2] == 1'b0) || (fall_b && low_sel_reg[2])) begin
        fine_applied_out2 <= fine_phase_out2;
      end
      if ((fall_a && low_sel_reg[3] == 1'b0) || (fall_b && low_sel_reg[3])) begin
        fine_applied_out3 <= fine_phase_out3;
      end
    end
  end

  // ----------------------------------------
  // Glitch-free source change
  // ----------------------------------------
  // The mux is parked for a short gap before the new source is taken,
  // which trades a brief low output for freedom from runt pulses
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_loop_b_sel <= `OCSS_RST_OUT_LOOP_B;
      out_upper_code <= `OCSS_RST_OUT_UPPER;
      out_switching <= 8'h00;
      pend_reg <= 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        gap_reg[k] <= 2'h0;
      end
    end else begin
      // A change during the gap is taken as the value at its end
      for (k = 0; k < 4; k = k + 1) begin
        if (out_loop_b_sel[k] != low_sel_reg[k] && !pend_reg[k]) begin
          pend_reg[k] <= 1'b1;
          out_switching[k] <= 1'b1;
          gap_reg[k] <= `OCSS_SWITCH_GAP;
        end else if (pend_reg[k] && gap_reg[k] != 2'h0) begin
          gap_reg[k] <= gap_reg[k] - 2'h1;
        end else if (pend_reg[k]) begin
          out_loop_b_sel[k] <= low_sel_reg[k];
          pend_reg[k] <= 1'b0;
          out_switching[k] <= 1'b0;
        end
        // Upper outputs never follow a loop_b select bit
        out_loop_b_sel[k + 4] <= 1'b0;
      end

      // Upper outputs wait out the same gap on a code change
      for (k = 4; k < 8; k = k + 1) begin
        if (out_upper_code[(k-4)*3 +: 3] != up_codes[(k-4)*3 +: 3] && !pend_reg[k]) begin
          pend_reg[k] <= 1'b1;
          out_switching[k] <= 1'b1;
          gap_reg[k] <= `OCSS_SWITCH_GAP;
        end else if (pend_reg[k] && gap_reg[k] != 2'h0) begin
          gap_reg[k] <= gap_reg[k] - 2'h1;
        end else if (pend_reg[k]) begin
          out_upper_code[(k-4)*3 +: 3] <= up_codes[(k-4)*3 +: 3];
          pend_reg[k] <= 1'b0;
          out_switching[k] <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/ocss_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ocss_assertions (
  // Watched ports
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] out_loop_b_sel,
  input wire logic [7:0] out_switching,
  input wire logic [7:0] divider_hold,
  input wire logic [7:0] coarse_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rsvd_read_a: assert property (reg_rd && reg_addr == 8'hab |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  sync_rsvd_bits_a: assert property (reg_rd && reg_addr == 8'ha8 |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  upper_no_b_a: assert property (out_loop_b_sel[7:4] == 4'h0)
    else $error("upper loop select set");
  clear_on_release_a: assert property ($fell(divider_hold[0]) |-> coarse_clear[0])
    else $error("no coarse clear at release");
  clear_cause_a: assert property (coarse_clear[2] |-> $past(divider_hold[2]) && !divider_hold[2])
    else $error("coarse clear without release");
  clear_pulse_a: assert property (coarse_clear[0] |=> !coarse_clear[0])
    else $error("coarse clear too long");
  release_together_a: assert property (out_loop_b_sel[0] == out_loop_b_sel[2]
    && divider_hold[0] && divider_hold[2] ##1 !divider_hold[0] |-> !divider_hold[2])
    else $error("releases apart");
  switch_gap_a: assert property ($rose(out_switching[0]) |-> ##[1:4] !out_switching[0])
    else $error("switch never ends");
  switch_safe_a: assert property ($changed(out_loop_b_sel[0]) |-> $past(out_switching[0]))
    else $error("select changed unguarded");
endmodule
bind ocss_source_ctrl ocss_assertions i_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_loop_b_sel(out_loop_b_sel),
  .out_switching(out_switching), .divider_hold(divider_hold), .coarse_clear(coarse_clear));
`default_nettype wire

/* File: tb/output_clock_source_sync_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module output_clock_source_sync_test;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, out_loop_b_sel;
  logic [7:0] out_switching, divider_hold, coarse_clear;
  logic [3:0] fine_phase_out2 = 4'h0, fine_phase_out3 = 4'h3, fine_applied_out2, fine_applied_out3;
  logic [11:0] out_upper_code;
  int n_mismatch = 0, cmp_count = 0;
  ocss_source_ctrl i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fine_phase_out2(fine_phase_out2),
    .fine_phase_out3(fine_phase_out3), .out_loop_b_sel(out_loop_b_sel),
    .out_upper_code(out_upper_code), .out_switching(out_switching), .divider_hold(divider_hold),
    .coarse_clear(coarse_clear), .fine_applied_out2(fine_applied_out2),
    .fine_applied_out3(fine_applied_out3));
  // ------
  // Access tasks
  // ------
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Whole run is well under 1000 cycles
  initial begin
    #50us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    wt(6);
    nrst = 1;
    rd(8'ha8, 8'h0a);
    rd(8'ha9, 8'h20);
    rd(8'haa, 8'h50);
    rd(8'hab, 8'h00);
    `CHK("upper", 12'ha10, out_upper_code)
    `CHK("low out", 8'h0a, out_loop_b_sel)
    wr(8'ha9, 8'h77);
    rd(8'ha9, 8'h77);
    // Reference inputs taken as slow enough for direct routing
    for (int c = 0; c < 8; c++) begin
      if (c != 6) begin
        wr(8'ha9, {5'h00, c[2:0]});
        wt(6);
        `CHK("code4", c[2:0], out_upper_code[2:0])
      end
    end
    wr(8'ha9, 8'h20);
    wt(6);
    fine_phase_out2 = 4'h9;
    wr(8'ha8, 8'h1a);
    wt(3);
    `CHK("hold a", 8'h75, divider_hold)
    wr(8'ha8, 8'h0a);
    wt(1);
    `CHK("clear a", 8'h75, coarse_clear)
    `CHK("release a", 8'h00, divider_hold)
    `CHK("fine2", 4'h9, fine_applied_out2)
    `CHK("fine3 kept", 4'h0, fine_applied_out3)
    wr(8'ha8, 8'h2a);
    wt(3);
    `CHK("hold b", 8'h0a, divider_hold)
    wr(8'ha8, 8'h0a);
    wr(8'ha8, 8'h05);
    wt(6);
    `CHK("sel low", 8'h05, out_loop_b_sel)
    `CHK("fine3", 4'h3, fine_applied_out3)
    finish_test();
  end
endmodule
`default_nettype wire
